// file: hw/wake_filter_media_status.sv
/*
  wake-frame configuration and media status registers with wake decision,
  flow-control gating and remote wakeup signalling.
  assumes one core clock, synchronous inputs, and that the receive path,
  pattern matcher, phy and usb core sit outside and drive the inputs.
*/
`timescale 1ns/1ps
module wake_filter_media_status
  import wake_media_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rx_done,
  input wire logic rx_frame_ok,
  input wire logic rx_dest_bcast,
  input wire logic rx_mcast_hash_hit,
  input wire logic rx_dest_station,
  input wire logic rx_pattern_a_crc_ok,
  input wire logic rx_pattern_b_crc_ok,
  input wire logic phy_link_up,
  input wire logic phy_speed_100,
  input wire logic phy_full_duplex,
  input wire logic [15:0] phy_basic_ctrl,
  input wire logic partner_fly,
  input wire logic mac_pause_sent,
  input wire logic mac_resume_sent,
  input wire logic mac_rx_paused,
  input wire logic eeprom_load,
  input wire logic eeprom_tx_pause_en,
  input wire logic usb_set_remote_wake,
  input wire logic usb_clr_remote_wake,
  input wire logic usb_suspended,
  output logic [4:1] pattern_frame_off,
  output logic long_pattern_a_en,
  output logic long_pattern_b_en,
  output logic tx_flow_active,
  output logic rx_flow_active,
  output logic wake_event,
  output logic usb_resume,
  output logic irq
);

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  reg_req_s req;
  rx_frame_s rxf;
  media_in_s med;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign rxf = '{frame_ok: rx_frame_ok, dest_bcast: rx_dest_bcast,
                 mcast_hash_hit: rx_mcast_hash_hit, dest_station: rx_dest_station,
                 pattern_a_crc_ok: rx_pattern_a_crc_ok,
                 pattern_b_crc_ok: rx_pattern_b_crc_ok};
  assign med = '{link_up: phy_link_up, speed_100: phy_speed_100,
                 full_duplex: phy_full_duplex, autoneg_on: phy_basic_ctrl[AUTONEG_ON_BIT],
                 partner_fly: partner_fly, pause_frame_sent: mac_pause_sent,
                 resume_frame_sent: mac_resume_sent, rx_paused: mac_rx_paused};

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  logic sel_cfg;
  logic sel_media;
  logic sel_irq_st;
  logic sel_irq_mask;

  assign sel_cfg = (req.addr == WAKE_FRAME_CONFIG_OFS);
  assign sel_media = (req.addr == MEDIA_STATE_OFS);
  assign sel_irq_st = (req.addr == WAKE_IRQ_STATUS_OFS);
  assign sel_irq_mask = (req.addr == WAKE_IRQ_MASK_OFS);

  // ------------------------------------------------------------
  // wake frame configuration
  // ------------------------------------------------------------
  logic [7:0] wake_cfg_r;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      wake_cfg_r <= WAKE_FRAME_CONFIG_RST;
    else if (req.wr && sel_cfg)
      wake_cfg_r <= req.wdata & WAKE_CFG_WMASK;
  end

  logic bcast_wake_en;
  logic mcast_wake_en;
  logic ucast_wake_en;

  assign bcast_wake_en = wake_cfg_r[BCAST_WAKE_BIT];
  assign mcast_wake_en = wake_cfg_r[MCAST_WAKE_BIT];
  assign ucast_wake_en = wake_cfg_r[UCAST_WAKE_BIT];
  assign long_pattern_a_en = wake_cfg_r[LONG_A_BIT];
  assign long_pattern_b_en = wake_cfg_r[LONG_B_BIT];
  // long patterns take over the masks of frames 1 to 4
  assign pattern_frame_off[1] = long_pattern_a_en;
  assign pattern_frame_off[2] = long_pattern_a_en;
  assign pattern_frame_off[3] = long_pattern_b_en;
  assign pattern_frame_off[4] = long_pattern_b_en;

  // ------------------------------------------------------------
  // flow control enables
  // ------------------------------------------------------------
  logic tx_pause_en_r;
  logic rx_pause_en_r;
  logic tx_pause_wr_ok;

  // locked while the partner negotiates pause on the fly
  assign tx_pause_wr_ok = !(med.autoneg_on && med.partner_fly);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      tx_pause_en_r <= 1'b0;
    // eeprom load wins over a software write
    else if (eeprom_load)
      tx_pause_en_r <= eeprom_tx_pause_en;
    else if (req.wr && sel_media && tx_pause_wr_ok)
      tx_pause_en_r <= req.wdata[TX_PAUSE_EN_BIT];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rx_pause_en_r <= 1'b0;
    else if (req.wr && sel_media)
      rx_pause_en_r <= req.wdata[RX_PAUSE_EN_BIT];
  end

  assign tx_flow_active = tx_pause_en_r && med.full_duplex;
  assign rx_flow_active = rx_pause_en_r && med.full_duplex;

  // ------------------------------------------------------------
  // media status
  // ------------------------------------------------------------
  logic tx_pause_sent_r;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      tx_pause_sent_r <= 1'b0;
    else if (med.pause_frame_sent)
      tx_pause_sent_r <= 1'b1;
    else if (med.resume_frame_sent)
      tx_pause_sent_r <= 1'b0;
  end

  logic [7:0] media_rd;

  always_comb
  begin
    media_rd = 8'h00;
    media_rd[TX_PAUSE_EN_BIT] = tx_pause_en_r;
    media_rd[RX_PAUSE_EN_BIT] = rx_pause_en_r;
    media_rd[DUPLEX_BIT] = med.full_duplex;
    media_rd[SPEED_BIT] = med.speed_100;
    media_rd[LINK_BIT] = med.link_up;
    media_rd[TX_PAUSE_SENT_BIT] = tx_pause_sent_r;
    media_rd[RX_PAUSED_BIT] = med.rx_paused;
  end

  // ------------------------------------------------------------
  // wake decision
  // ------------------------------------------------------------
  logic remote_wake_armed_r;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      remote_wake_armed_r <= 1'b0;
    else if (usb_set_remote_wake)
      remote_wake_armed_r <= 1'b1;
    else if (usb_clr_remote_wake)
      remote_wake_armed_r <= 1'b0;
  end

  logic good_frame;
  logic wake_hit;

  assign good_frame = rx_done && rxf.frame_ok;
  always_comb
  begin
    wake_hit = 1'b0;
    if (bcast_wake_en && rxf.dest_bcast)
      wake_hit = 1'b1;
    if (mcast_wake_en && rxf.mcast_hash_hit)
      wake_hit = 1'b1;
    if (ucast_wake_en && rxf.dest_station)
      wake_hit = 1'b1;
    if (long_pattern_a_en && rxf.pattern_a_crc_ok)
      wake_hit = 1'b1;
    if (long_pattern_b_en && rxf.pattern_b_crc_ok)
      wake_hit = 1'b1;
  end

  logic wake_req;

  assign wake_req = good_frame && wake_hit && remote_wake_armed_r;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      wake_event <= 1'b0;
    else
      wake_event <= wake_req;
  end

  // ------------------------------------------------------------
  // remote wakeup resume
  // ------------------------------------------------------------
  rwake_e rw_state_r;
  rwake_e rw_state_nxt;
  logic [3:0] resume_cnt_r;

  always_comb
  begin
    rw_state_nxt = rw_state_r;
    case (rw_state_r)
      RW_IDLE:
        if (wake_req && usb_suspended)
          rw_state_nxt = RW_ARMED;
      RW_ARMED:
        if (!usb_suspended || !remote_wake_armed_r)
          rw_state_nxt = RW_IDLE;
        else
          rw_state_nxt = RW_SIGNAL;
      RW_SIGNAL:
        if (resume_cnt_r == 4'h1)
          rw_state_nxt = RW_IDLE;
      default:
        rw_state_nxt = RW_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rw_state_r <= RW_IDLE;
    else
      rw_state_r <= rw_state_nxt;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      resume_cnt_r <= 4'h0;
    else if (rw_state_nxt == RW_SIGNAL && rw_state_r != RW_SIGNAL)
      resume_cnt_r <= RESUME_CYCLES;
    else if (rw_state_r == RW_SIGNAL)
      resume_cnt_r <= resume_cnt_r - 4'h1;
  end

  assign usb_resume = (rw_state_r == RW_SIGNAL);

  // ------------------------------------------------------------
  // interrupt status and mask
  // ------------------------------------------------------------
  logic [7:0] irq_mask_r;
  logic [7:0] irq_set;
  logic [7:0] irq_status;
  logic irq_clr;

  always_comb
  begin
    irq_set = 8'h00;
    irq_set[IRQ_WAKE_BIT] = wake_req;
    irq_set[IRQ_PAUSE_SENT_BIT] = med.pause_frame_sent;
    irq_set[IRQ_RESUME_SENT_BIT] = med.resume_frame_sent;
  end
  assign irq_clr = req.rd && sel_irq_st;

  // set wins over the read clear
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_flag
      sticky_flag u_flag
      (
        .clock(clock),
        .rst_n(rst_n),
        .set(irq_set[gi]),
        .clr(irq_clr),
        .flag_r(irq_status[gi])
      );
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq_mask_r <= IRQ_MASK_RST;
    else if (req.wr && sel_irq_mask)
      irq_mask_r <= req.wdata;
  end

  assign irq = |(irq_status & irq_mask_r);

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  // read data stands one cycle, zero otherwise
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (req.rd)
    begin
      if (sel_cfg)
        reg_rdata <= wake_cfg_r;
      else if (sel_media)
        reg_rdata <= media_rd;
      else if (sel_irq_st)
        reg_rdata <= irq_status;
      else if (sel_irq_mask)
        reg_rdata <= irq_mask_r;
      else
        reg_rdata <= 8'h00;
    end
    else
      reg_rdata <= 8'h00;
  end

endmodule

// file: hw/wake_media_pkg.sv
/*
  package for the wake-frame configuration and media status register bank.
  assumes a single core clock and a plain register port with byte data.
*/
package wake_media_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [15:0] WAKE_FRAME_CONFIG_OFS = 16'h0136;
  localparam logic [15:0] MEDIA_STATE_OFS = 16'h0137;
  localparam logic [15:0] WAKE_IRQ_STATUS_OFS = 16'h0150;
  localparam logic [15:0] WAKE_IRQ_MASK_OFS = 16'h0151;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BCAST_WAKE_BIT = 6;
  localparam int MCAST_WAKE_BIT = 5;
  localparam int UCAST_WAKE_BIT = 4;
  localparam int LONG_B_BIT = 1;
  localparam int LONG_A_BIT = 0;
  localparam int TX_PAUSE_EN_BIT = 7;
  localparam int RX_PAUSE_EN_BIT = 6;
  localparam int DUPLEX_BIT = 4;
  localparam int SPEED_BIT = 3;
  localparam int LINK_BIT = 2;
  localparam int TX_PAUSE_SENT_BIT = 1;
  localparam int RX_PAUSED_BIT = 0;
  localparam int AUTONEG_ON_BIT = 12;
  localparam int IRQ_WAKE_BIT = 0;
  localparam int IRQ_PAUSE_SENT_BIT = 2;
  localparam int IRQ_RESUME_SENT_BIT = 3;

  // ------------------------------------------------------------
  // reset values, config write mask and resume length
  // ------------------------------------------------------------
  localparam logic [7:0] WAKE_FRAME_CONFIG_RST = 8'h00;
  localparam logic [7:0] WAKE_CFG_WMASK = 8'h73;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam logic [3:0] RESUME_CYCLES = 4'h8;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic frame_ok;
    logic dest_bcast;
    logic mcast_hash_hit;
    logic dest_station;
    logic pattern_a_crc_ok;
    logic pattern_b_crc_ok;
  } rx_frame_s;

  typedef struct packed {
    logic link_up;
    logic speed_100;
    logic full_duplex;
    logic autoneg_on;
    logic partner_fly;
    logic pause_frame_sent;
    logic resume_frame_sent;
    logic rx_paused;
  } media_in_s;

  typedef enum logic [1:0] {
    RW_IDLE = 2'b00,
    RW_ARMED = 2'b01,
    RW_SIGNAL = 2'b11
  } rwake_e;

endpackage

// file: hw/sticky_flag.sv
/*
  one sticky status flag: set wins over clear.
  assumes synchronous set and clear pulses on the core clock.
*/
`timescale 1ns/1ps
module sticky_flag
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic set,
  input wire logic clr,
  output logic flag_r
);

  // ------------------------------------------------------------
  // flag
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      flag_r <= 1'b0;
    else if (set)
      flag_r <= 1'b1;
    else if (clr)
      flag_r <= 1'b0;
  end

endmodule

// file: verif/wake_frame_source.sv
/*
  frame source for the receive path side of the bank.
  assumes send is a one clock pulse with the class in cls.
*/
`timescale 1ns/1ps
module wake_frame_source
  import wake_media_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic send,
  input wire rx_frame_s cls,
  output rx_frame_s frm,
  output logic done_r
);
  // ----
  // frame strobe
  // ----
  logic tog_r;
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      done_r <= 1'b0;
      tog_r <= 1'b0;
      frm <= '0;
    end
    else
    begin
      done_r <= send;
      tog_r <= ~tog_r;
      // class lines churn outside the strobe
      frm <= send ? cls : {6{tog_r}};
    end
endmodule

// file: verif/wake_filter_media_status_assertions.sv
/*
  concurrent checks on the wake and media bank.
  assumes a bind onto the top module ports.
*/
`timescale 1ns/1ps
module wake_media_checks
  import wake_media_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic rx_done,
  input wire logic rx_frame_ok,
  input wire logic phy_link_up,
  input wire logic phy_speed_100,
  input wire logic phy_full_duplex,
  input wire logic [4:1] pattern_frame_off,
  input wire logic long_pattern_a_en,
  input wire logic long_pattern_b_en,
  input wire logic tx_flow_active,
  input wire logic rx_flow_active,
  input wire logic wake_event,
  input wire logic usb_resume
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_cfg_rsvd;
    reg_rd && reg_addr == WAKE_FRAME_CONFIG_OFS |=> reg_rdata[7] == 1'b0 && reg_rdata[3:2] == 2'h0;
  endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd)
    else $error("cfg reserved bits set");
  property p_media_st;
    reg_rd && reg_addr == MEDIA_STATE_OFS |=>
      reg_rdata[4:2] == {$past(phy_full_duplex), $past(phy_speed_100), $past(phy_link_up)};
  endproperty
  a_media_st: assert property (p_media_st)
    else $error("media state bits wrong");
  property p_tx_flow;
    tx_flow_active |-> phy_full_duplex;
  endproperty
  a_tx_flow: assert property (p_tx_flow)
    else $error("tx flow outside full duplex");
  property p_rx_flow;
    rx_flow_active |-> phy_full_duplex;
  endproperty
  a_rx_flow: assert property (p_rx_flow)
    else $error("rx flow outside full duplex");
  property p_off_a;
    pattern_frame_off[2:1] == {2{long_pattern_a_en}};
  endproperty
  a_off_a: assert property (p_off_a)
    else $error("frames 1 2 gating wrong");
  property p_off_b;
    pattern_frame_off[4:3] == {2{long_pattern_b_en}};
  endproperty
  a_off_b: assert property (p_off_b)
    else $error("frames 3 4 gating wrong");
  property p_wake_src;
    wake_event |-> $past(rx_done) && $past(rx_frame_ok);
  endproperty
  a_wake_src: assert property (p_wake_src)
    else $error("wake without good frame");
  property p_res_src;
    $rose(usb_resume) |-> $past(wake_event);
  endproperty
  a_res_src: assert property (p_res_src)
    else $error("resume without wake");
  property p_res_len;
    $rose(usb_resume) |-> usb_resume [*8] ##1 !usb_resume;
  endproperty
  a_res_len: assert property (p_res_len)
    else $error("resume length wrong");
  property p_tx_flow_rd;
    reg_rd && reg_addr == MEDIA_STATE_OFS && phy_full_duplex |=>
      reg_rdata[7] == $past(tx_flow_active);
  endproperty
  a_tx_flow_rd: assert property (p_tx_flow_rd)
    else $error("tx flow not following enable in full duplex");
  property p_rx_flow_rd;
    reg_rd && reg_addr == MEDIA_STATE_OFS && phy_full_duplex |=>
      reg_rdata[6] == $past(rx_flow_active);
  endproperty
  a_rx_flow_rd: assert property (p_rx_flow_rd)
    else $error("rx flow not following enable in full duplex");
  property p_cfg_long;
    reg_rd && reg_addr == WAKE_FRAME_CONFIG_OFS |=>
      reg_rdata[1:0] == {$past(long_pattern_b_en), $past(long_pattern_a_en)};
  endproperty
  a_cfg_long: assert property (p_cfg_long)
    else $error("long pattern enables differ from register");
endmodule

// file: verif/test_wake_filter_media_status.sv
/*
  self-checking bench for the wake and media bank.
  assumes the frame source model and the bound checker.
*/
`timescale 1ns/1ps
module test_wake_filter_media_status
  import wake_media_pkg::*;
;
  logic clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, send = 0;
  logic [15:0] reg_addr = 16'h0000, phy_basic_ctrl = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, v;
  logic phy_link_up = 0, phy_speed_100 = 0, phy_full_duplex = 0, partner_fly = 0;
  logic mac_pause_sent = 0, mac_resume_sent = 0, mac_rx_paused = 0;
  logic eeprom_load = 0, eeprom_tx_pause_en = 0, usb_suspended = 0;
  logic usb_set_remote_wake = 0, usb_clr_remote_wake = 0;
  logic [4:1] pattern_frame_off;
  logic long_pattern_a_en, long_pattern_b_en, tx_flow_active, rx_flow_active;
  logic wake_event, usb_resume, irq, rx_done;
  rx_frame_s cls = '0, frm;
  int error_cnt = 0, samples_checked = 0;
  // ----
  // harness
  // ----
  always #5 clock = ~clock;
  wake_frame_source u_src (.clock, .rst_n, .send, .cls, .frm, .done_r(rx_done));
  wake_filter_media_status DUT (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .rx_done, .rx_frame_ok(frm.frame_ok), .rx_dest_bcast(frm.dest_bcast),
    .rx_mcast_hash_hit(frm.mcast_hash_hit), .rx_dest_station(frm.dest_station),
    .rx_pattern_a_crc_ok(frm.pattern_a_crc_ok), .rx_pattern_b_crc_ok(frm.pattern_b_crc_ok),
    .phy_link_up, .phy_speed_100, .phy_full_duplex, .phy_basic_ctrl, .partner_fly,
    .mac_pause_sent, .mac_resume_sent, .mac_rx_paused, .eeprom_load, .eeprom_tx_pause_en,
    .usb_set_remote_wake, .usb_clr_remote_wake, .usb_suspended, .pattern_frame_off,
    .long_pattern_a_en, .long_pattern_b_en, .tx_flow_active, .rx_flow_active,
    .wake_event, .usb_resume, .irq);
  // ----
  // tasks
  // ----
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock) reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock) reg_wr <= 0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] m);
    @(posedge clock) reg_rd <= 1;
    reg_addr <= a;
    @(posedge clock) reg_rd <= 0;
    @(negedge clock) v = reg_rdata & m;
  endtask
  task automatic frame(input rx_frame_s c, input logic we, input logic re);
    @(posedge clock) send <= 1;
    cls <= c;
    @(posedge clock) send <= 0;
    @(posedge clock);
    #1;
    chk("wake", {7'h0, we}, {7'h0, wake_event});
    @(posedge clock);
    #1;
    chk("resume", {7'h0, re}, {7'h0, usb_resume});
    repeat (10) @(posedge clock);
  endtask
  task automatic t_cfg;
    rd(WAKE_FRAME_CONFIG_OFS, 8'hff);
    chk("cfg reset", WAKE_FRAME_CONFIG_RST, v);
    rd(16'h0140, 8'hff);
    chk("unmapped", 8'h00, v);
    wr(WAKE_FRAME_CONFIG_OFS, 8'hff);
    rd(WAKE_FRAME_CONFIG_OFS, 8'hff);
    chk("cfg rw", WAKE_CFG_WMASK, v);
    for (int i = 0; i < 4; i++)
    begin
      wr(WAKE_FRAME_CONFIG_OFS, 8'(i));
      chk("long en", 8'(i), {6'h0, long_pattern_b_en, long_pattern_a_en});
      chk("off", {4'h0, {2{i[1]}}, {2{i[0]}}}, {4'h0, pattern_frame_off});
    end
  endtask
  task automatic t_media;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clock) {mac_rx_paused, phy_full_duplex, phy_speed_100, phy_link_up} <= 4'(i);
      rd(MEDIA_STATE_OFS, 8'h3d);
      chk("media", {3'h0, i[2], i[1], i[0], 1'b0, i[3]}, v);
    end
    @(posedge clock) mac_pause_sent <= 1;
    @(posedge clock) mac_pause_sent <= 0;
    rd(MEDIA_STATE_OFS, 8'h02);
    chk("pause sent", 8'h02, v);
    @(posedge clock) mac_resume_sent <= 1;
    @(posedge clock) mac_resume_sent <= 0;
    rd(MEDIA_STATE_OFS, 8'h02);
    chk("resume sent", 8'h00, v);
    rd(WAKE_IRQ_STATUS_OFS, 8'hff);
    chk("status", 8'h0c, v);
  endtask
  task automatic t_flow;
    @(posedge clock) phy_full_duplex <= 1;
    partner_fly <= 1;
    wr(MEDIA_STATE_OFS, 8'hc0);
    rd(MEDIA_STATE_OFS, 8'hc0);
    chk("pause en", 8'hc0, v);
    chk("flow fd", 8'h03, {6'h0, tx_flow_active, rx_flow_active});
    @(posedge clock) phy_full_duplex <= 0;
    @(negedge clock) chk("flow hd", 8'h00, {6'h0, tx_flow_active, rx_flow_active});
    @(posedge clock) phy_basic_ctrl <= 16'h1000;
    wr(MEDIA_STATE_OFS, 8'h00);
    rd(MEDIA_STATE_OFS, 8'hc0);
    chk("tx en locked", 8'h80, v);
    @(posedge clock) partner_fly <= 0;
    wr(MEDIA_STATE_OFS, 8'h00);
    rd(MEDIA_STATE_OFS, 8'h80);
    chk("tx en open", 8'h00, v);
    @(posedge clock) eeprom_load <= 1;
    eeprom_tx_pause_en <= 1;
    @(posedge clock) eeprom_load <= 0;
    rd(MEDIA_STATE_OFS, 8'h80);
    chk("tx en load", 8'h80, v);
  endtask
  task automatic t_wake;
    wr(WAKE_IRQ_MASK_OFS, 8'h01);
    @(posedge clock) usb_set_remote_wake <= 1;
    usb_suspended <= 1;
    @(posedge clock) usb_set_remote_wake <= 0;
    for (int i = 0; i < 3; i++)
    begin
      wr(WAKE_FRAME_CONFIG_OFS, 8'h40 >> i);
      frame(6'h20 | (6'h10 >> i), 1, 1);
      chk("irq set", 8'h01, {7'h0, irq});
      rd(WAKE_IRQ_STATUS_OFS, 8'hff);
      chk("status wake", 8'h01, v);
      chk("irq clr", 8'h00, {7'h0, irq});
      frame(6'h10 >> i, 0, 0);
      frame(6'h20 | (6'h10 >> ((i + 1) % 3)), 0, 0);
    end
    @(posedge clock) usb_suspended <= 0;
    wr(WAKE_FRAME_CONFIG_OFS, 8'h01);
    frame(6'h22, 1, 0);
    frame(6'h21, 0, 0);
    wr(WAKE_FRAME_CONFIG_OFS, 8'h02);
    frame(6'h21, 1, 0);
    frame(6'h22, 0, 0);
    wr(WAKE_FRAME_CONFIG_OFS, 8'h10);
    @(posedge clock) usb_clr_remote_wake <= 1;
    @(posedge clock) usb_clr_remote_wake <= 0;
    frame(6'h24, 0, 0);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial
  begin
    repeat (12) @(posedge clock);
    rst_n <= 1;
    t_cfg();
    t_media();
    t_flow();
    t_wake();
    test_done();
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    test_done();
  end
endmodule
bind wake_filter_media_status wake_media_checks u_chk (.clock, .rst_n, .reg_addr, .reg_rd,
  .reg_rdata, .rx_done, .rx_frame_ok, .phy_link_up, .phy_speed_100, .phy_full_duplex,
  .pattern_frame_off, .long_pattern_a_en, .long_pattern_b_en, .tx_flow_active,
  .rx_flow_active, .wake_event, .usb_resume);
